// file: rtl/msr_pkg.sv
// Constants, field layouts and carrier types of the sensor settings bank.
// Assumes a serial framer outside splits every bus request into one item.
package msr_pkg;
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned HOLD_MS = 5000;
	localparam longint unsigned HOLD_CYC = longint'(HOLD_MS) * CLK_HZ / 1000;
	localparam int unsigned EXIT_MIN = 10;
	localparam longint unsigned EXIT_CYC = longint'(EXIT_MIN) * 60 * CLK_HZ;
	localparam int unsigned BLINK_MS = 250;
	localparam longint unsigned BLINK_CYC = longint'(BLINK_MS) * CLK_HZ / 1000;
	localparam logic [7:0] FC_RD_COILS = 8'h01;
	localparam logic [7:0] FC_RD_HOLD = 8'h03;
	localparam logic [7:0] FC_WR_COILS = 8'h0f;
	localparam logic [7:0] FC_WR_REGS = 8'h10;
	localparam logic [7:0] EX_FUNC = 8'h01;
	localparam logic [7:0] EX_ADDR = 8'h02;
	localparam logic [15:0] OFS_PART = 16'h0001;
	localparam logic [15:0] OFS_FW = 16'h0002;
	localparam logic [15:0] OFS_HW = 16'h0003;
	localparam logic [15:0] OFS_STATION = 16'h0004;
	localparam logic [15:0] OFS_LINE = 16'h0005;
	localparam logic [15:0] OFS_CMD = 16'h0007;
	localparam logic [15:0] OFS_LUX = 16'h0008;
	localparam logic [15:0] OFS_OCC = 16'h0009;
	localparam logic [15:0] OFS_ON = 16'h000a;
	localparam logic [15:0] OFS_OFF = 16'h000b;
	localparam logic [15:0] OFS_SMP = 16'h000c;
	localparam logic [15:0] OFS_IND = 16'h000d;
	localparam logic [15:0] OFS_SENS = 16'h000e;
	localparam int unsigned CMD_RESTORE = 0;
	localparam int unsigned CMD_EXIT = 1;
	localparam int unsigned PAR_LSB = 8;
	localparam int unsigned STOP_POS = 10;
	localparam logic [15:0] STATION_MIN = 16'h0001;
	localparam logic [15:0] STATION_MAX = 16'h00fa;
	localparam logic [7:0] BAUD_MIN = 8'h01;
	localparam logic [7:0] BAUD_MAX = 8'h08;
	localparam logic [1:0] PAR_NONE = 2'b00;
	localparam logic [1:0] CODE_BAD = 2'b11;
	localparam logic [15:0] ON_MAX = 16'h012c;
	localparam logic [15:0] OFF_MIN = 16'h0005;
	localparam logic [15:0] OFF_MAX = 16'h0708;
	localparam logic [15:0] SMP_MIN = 16'h0002;
	localparam logic [15:0] SMP_MAX = 16'h003c;
	localparam logic [15:0] LUX_MAX = 16'h07d0;
	localparam logic [15:0] RST_STATION = 16'h0001;
	localparam logic [15:0] RST_LINE = 16'h0004;
	localparam logic [15:0] RST_ON = 16'h0000;
	localparam logic [15:0] RST_OFF = 16'h0258;
	localparam logic [15:0] RST_SMP = 16'h000f;
	localparam logic [15:0] RST_IND = 16'h0001;
	localparam logic [15:0] RST_SENS = 16'h0001;
	localparam logic [7:0] CFG_STATION = 8'h01;
	localparam logic [3:0] CFG_BAUD = 4'h4;

	typedef enum logic [2:0] {
		MODE_RUN = 3'b001,
		MODE_CFG = 3'b010,
		MODE_SET = 3'b100
	} msr_mode_type;

	typedef struct packed {
		logic [15:0] station;
		logic [15:0] line;
		logic [15:0] on_dly;
		logic [15:0] off_dly;
		logic [15:0] smp;
		logic [15:0] ind;
		logic [15:0] sens;
	} msr_cfg_type;

	localparam msr_cfg_type CFG_DEFAULT = '{RST_STATION, RST_LINE, RST_ON, RST_OFF, RST_SMP, RST_IND, RST_SENS};

	typedef struct packed {
		logic valid;
		logic [7:0] func;
		logic [15:0] addr;
		logic [15:0] data;
	} msr_req_type;

	typedef struct packed {
		logic valid;
		logic exc;
		logic [7:0] code;
		logic [15:0] data;
	} msr_rsp_type;

	typedef struct packed {
		logic [7:0] station;
		logic [3:0] baud;
		logic [1:0] parity;
		logic two_stop;
	} msr_link_type;

	typedef struct packed {
		msr_mode_type mode;
		logic [31:0] hold_cnt;
		logic [32:0] tmo_cnt;
		logic [31:0] blink_cnt;
		logic blink;
		msr_cfg_type cfg;
		msr_rsp_type rsp;
		logic nvm_save;
	} msr_state_type;
endpackage

// file: rtl/msr_register_bank.sv
// Register and coil bank of the occupancy and daylight sensor, with setting mode.
// Assumes one decoded request item per cycle and external nonvolatile storage.
// Operation
// - Word reads with function 03 and word writes with 16; registers are 16 bits.
// - Bit reads with function 01 and bit writes with function 15.
// - Button held five seconds enters setting mode with indicator steadily on.
// - In setting mode the link runs at station 1, 9600, no parity, one stop.
// - Command value one restores defaults, blinks, and opens address and line writes; outside setting mode the code only restores defaults.
// - Command value two leaves setting mode; otherwise leave after ten minutes.
// - Command bit 0 restores defaults, bit 1 exits; clear bits do nothing.
// - Reading the command register always returns zero.
// - Station number accepts 1 to 250 and defaults to 1.
// - Line format low byte codes 1 to 8 select baud; default code 4.
// - Stop flag gives two stop bits only with no parity.
// - Light reading reports lux directly, limited to 2000.
// - Presence bit 0 reads 1 when occupied, 0 when vacant.
// - Turn-on delay 0 disables, 1 to 300 seconds valid, larger ignored.
// - Turn-off delay accepts 5 to 1800 seconds, default 600.
// - Light sample period accepts 2 to 60 seconds, default 15.
// - Indicator control bit 0 enables the indicator light; default enabled.
// - Sensitivity 00 high, 01 normal, 10 low, 11 ignored; default normal.
// - Settings are kept in nonvolatile storage.
// - Firmware and hardware revisions are read-only nonzero words.
`timescale 1ns/10ps
`default_nettype none

module msr_register_bank #(
	parameter longint unsigned HOLD_CYCLES = msr_pkg::HOLD_CYC,
	parameter longint unsigned EXIT_CYCLES = msr_pkg::EXIT_CYC,
	parameter longint unsigned BLINK_CYCLES = msr_pkg::BLINK_CYC,
	// Identification values are arbitrary and nonzero.
	parameter logic [15:0] PART_ID = 16'h5a01,
	parameter logic [15:0] FW_REV = 16'h0101,
	parameter logic [15:0] HW_REV = 16'h0201
) (
	// Clock and control
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	// Request and answer
	input wire msr_pkg::msr_req_type req,
	output var msr_pkg::msr_rsp_type rsp,
	// Sensor side
	input wire logic button_held,
	input wire logic occupied,
	input wire logic [15:0] lux,
	// Nonvolatile storage
	input wire logic nvm_load,
	input wire msr_pkg::msr_cfg_type nvm_data,
	output logic nvm_save,
	// Settings and indication
	output var msr_pkg::msr_cfg_type settings,
	output var msr_pkg::msr_link_type link_cfg,
	output logic config_active,
	output logic indicator_light
);
	msr_pkg::msr_state_type q;
	msr_pkg::msr_state_type d;
	logic [15:0] idx;
	logic [15:0] rd_word;
	logic [15:0] wr_word;
	logic is_coil;
	logic is_write;
	logic func_ok;

	function automatic logic is_mapped(input logic [15:0] a);
		is_mapped = (a >= msr_pkg::OFS_PART && a <= msr_pkg::OFS_LINE) ||
			(a >= msr_pkg::OFS_CMD && a <= msr_pkg::OFS_SENS);
	endfunction

	function automatic logic is_writable(input logic [15:0] a);
		is_writable = !(a <= msr_pkg::OFS_HW || a == msr_pkg::OFS_LUX || a == msr_pkg::OFS_OCC);
	endfunction

	// Out-of-range values are dropped silently and answered normally.
	function automatic logic value_ok(input logic [15:0] a, input logic [15:0] v, input logic set_mode);
		case (a)
		msr_pkg::OFS_STATION: value_ok = set_mode && v >= msr_pkg::STATION_MIN && v <= msr_pkg::STATION_MAX;
		msr_pkg::OFS_LINE: value_ok = set_mode && v[7:0] >= msr_pkg::BAUD_MIN && v[7:0] <= msr_pkg::BAUD_MAX &&
			v[9:8] != msr_pkg::CODE_BAD && v[15:11] == 5'h00;
		msr_pkg::OFS_ON: value_ok = v <= msr_pkg::ON_MAX;
		msr_pkg::OFS_OFF: value_ok = v >= msr_pkg::OFF_MIN && v <= msr_pkg::OFF_MAX;
		msr_pkg::OFS_SMP: value_ok = v >= msr_pkg::SMP_MIN && v <= msr_pkg::SMP_MAX;
		msr_pkg::OFS_IND: value_ok = v[15:1] == 15'h0000;
		msr_pkg::OFS_SENS: value_ok = v[1:0] != msr_pkg::CODE_BAD && v[15:2] == 14'h0000;
		default: value_ok = 1'b1;
		endcase
	endfunction

	assign is_coil = req.func == msr_pkg::FC_RD_COILS || req.func == msr_pkg::FC_WR_COILS;
	assign is_write = req.func == msr_pkg::FC_WR_REGS || req.func == msr_pkg::FC_WR_COILS;
	assign func_ok = is_coil || req.func == msr_pkg::FC_RD_HOLD || req.func == msr_pkg::FC_WR_REGS;
	// Coil number is the register index times sixteen plus the bit.
	assign idx = is_coil ? {4'h0, req.addr[15:4]} : req.addr;

	always_comb begin
		case (idx)
		msr_pkg::OFS_PART: rd_word = PART_ID;
		msr_pkg::OFS_FW: rd_word = FW_REV;
		msr_pkg::OFS_HW: rd_word = HW_REV;
		msr_pkg::OFS_STATION: rd_word = q.cfg.station;
		msr_pkg::OFS_LINE: rd_word = q.cfg.line;
		msr_pkg::OFS_LUX: rd_word = (lux > msr_pkg::LUX_MAX) ? msr_pkg::LUX_MAX : lux;
		msr_pkg::OFS_OCC: rd_word = {15'h0000, occupied};
		msr_pkg::OFS_ON: rd_word = q.cfg.on_dly;
		msr_pkg::OFS_OFF: rd_word = q.cfg.off_dly;
		msr_pkg::OFS_SMP: rd_word = q.cfg.smp;
		msr_pkg::OFS_IND: rd_word = q.cfg.ind;
		msr_pkg::OFS_SENS: rd_word = q.cfg.sens;
		default: rd_word = 16'h0000;
		endcase
	end

	always_comb begin
		wr_word = rd_word;
		if (is_coil) begin
			wr_word[req.addr[3:0]] = req.data[0];
		end else begin
			wr_word = req.data;
		end
	end

	always_comb begin
		d = q;
		d.rsp = '0;
		d.nvm_save = 1'b0;
		if (nvm_load) begin
			d.cfg = nvm_data;
		end
		case (q.mode)
		msr_pkg::MODE_RUN: begin
			d.tmo_cnt = '0;
			d.blink_cnt = '0;
			d.blink = 1'b0;
			if (!button_held) begin
				d.hold_cnt = '0;
			end else if (q.hold_cnt == 32'(HOLD_CYCLES - 1)) begin
				d.hold_cnt = '0;
				d.mode = msr_pkg::MODE_CFG;
			end else begin
				d.hold_cnt = q.hold_cnt + 32'h1;
			end
		end
		msr_pkg::MODE_CFG, msr_pkg::MODE_SET: begin
			d.hold_cnt = '0;
			if (q.tmo_cnt == 33'(EXIT_CYCLES - 1)) begin
				d.mode = msr_pkg::MODE_RUN;
			end else begin
				d.tmo_cnt = q.tmo_cnt + 33'h1;
			end
			if (q.mode == msr_pkg::MODE_SET) begin
				if (q.blink_cnt == 32'(BLINK_CYCLES - 1)) begin
					d.blink_cnt = '0;
					d.blink = !q.blink;
				end else begin
					d.blink_cnt = q.blink_cnt + 32'h1;
				end
			end
		end
		default: d.mode = msr_pkg::MODE_RUN;
		endcase
		if (req.valid) begin
			d.rsp.valid = 1'b1;
			if (!func_ok) begin
				d.rsp.exc = 1'b1;
				d.rsp.code = msr_pkg::EX_FUNC;
			end else if (!is_mapped(idx) || (is_write && !is_writable(idx))) begin
				d.rsp.exc = 1'b1;
				d.rsp.code = msr_pkg::EX_ADDR;
			end else if (!is_write) begin
				d.rsp.data = is_coil ? {15'h0000, rd_word[req.addr[3:0]]} : rd_word;
			end else if (idx == msr_pkg::OFS_CMD) begin
				if (wr_word[msr_pkg::CMD_RESTORE]) begin
					d.cfg = msr_pkg::CFG_DEFAULT;
					d.nvm_save = 1'b1;
					// Decided on the present mode, so a restore still wins over a timeout in the same cycle.
					if (q.mode != msr_pkg::MODE_RUN) begin
						d.mode = msr_pkg::MODE_SET;
					end
				end
				if (wr_word[msr_pkg::CMD_EXIT]) begin
					d.mode = msr_pkg::MODE_RUN;
				end
			end else if (value_ok(idx, wr_word, q.mode == msr_pkg::MODE_SET)) begin
				d.nvm_save = 1'b1;
				case (idx)
				msr_pkg::OFS_STATION: d.cfg.station = wr_word;
				msr_pkg::OFS_LINE: d.cfg.line = wr_word;
				msr_pkg::OFS_ON: d.cfg.on_dly = wr_word;
				msr_pkg::OFS_OFF: d.cfg.off_dly = wr_word;
				msr_pkg::OFS_SMP: d.cfg.smp = wr_word;
				msr_pkg::OFS_IND: d.cfg.ind = wr_word;
				msr_pkg::OFS_SENS: d.cfg.sens = wr_word;
				default: d.nvm_save = 1'b0;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			q.mode <= msr_pkg::MODE_RUN;
			q.hold_cnt <= '0;
			q.tmo_cnt <= '0;
			q.blink_cnt <= '0;
			q.blink <= 1'b0;
			q.cfg <= msr_pkg::CFG_DEFAULT;
			q.rsp <= '0;
			q.nvm_save <= 1'b0;
		end else if (ce) begin
			q <= d;
		end
	end

	assign rsp = q.rsp;
	assign nvm_save = q.nvm_save;
	assign settings = q.cfg;
	assign config_active = q.mode != msr_pkg::MODE_RUN;

	// Stored line values only take effect after setting mode ends, so the master never loses the link mid-edit.
	always_comb begin
		if (config_active) begin
			link_cfg.station = msr_pkg::CFG_STATION;
			link_cfg.baud = msr_pkg::CFG_BAUD;
			link_cfg.parity = msr_pkg::PAR_NONE;
			link_cfg.two_stop = 1'b0;
		end else begin
			link_cfg.station = q.cfg.station[7:0];
			link_cfg.baud = q.cfg.line[3:0];
			link_cfg.parity = q.cfg.line[msr_pkg::PAR_LSB +: 2];
			link_cfg.two_stop = q.cfg.line[msr_pkg::STOP_POS] && q.cfg.line[msr_pkg::PAR_LSB +: 2] == msr_pkg::PAR_NONE;
		end
	end

	always_comb begin
		case (q.mode)
		msr_pkg::MODE_CFG: indicator_light = 1'b1;
		msr_pkg::MODE_SET: indicator_light = q.blink;
		default: indicator_light = q.cfg.ind[0] && occupied;
		endcase
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	a_rsp_latency: assert property (ce && req.valid |=> rsp.valid)
		else $error("Request got no answer in the next cycle.");
	a_bad_func: assert property (ce && !nvm_load && req.valid && !func_ok |=>
		rsp.exc && rsp.code == 8'h01 && $stable(settings))
		else $error("Unsupported function not refused.");
	a_cmd_read_zero: assert property (ce && req.valid && req.func == 8'h03 && req.addr == 16'h0007 |=> rsp.data == 16'h0000)
		else $error("Command register read back nonzero.");
	a_button_enter: assert property (ce && q.mode == msr_pkg::MODE_RUN && button_held &&
		q.hold_cnt == 32'(HOLD_CYCLES - 1) |=> config_active && indicator_light)
		else $error("Button hold did not enter setting mode.");
	a_link_default: assert property (config_active |-> link_cfg.station == 8'h01 && link_cfg.baud == 4'h4 &&
		link_cfg.parity == 2'b00 && !link_cfg.two_stop)
		else $error("Setting mode link values wrong.");
	a_restore_cmd: assert property (ce && !nvm_load && req.valid && req.func == 8'h10 && req.addr == 16'h0007 &&
		req.data[1:0] == 2'b01 |=> settings == msr_pkg::CFG_DEFAULT && nvm_save)
		else $error("Restore command did not load defaults.");
	a_exit_cmd: assert property (ce && req.valid && req.func == 8'h10 && req.addr == 16'h0007 &&
		req.data[1] |=> !config_active)
		else $error("Exit command did not leave setting mode.");
	a_tmo_exit: assert property (ce && config_active && q.tmo_cnt == 33'(EXIT_CYCLES - 1) &&
		!(req.valid && req.addr == 16'h0007) |=> !config_active)
		else $error("Setting mode did not time out.");
	a_two_stop: assert property (link_cfg.two_stop |-> link_cfg.parity == 2'b00)
		else $error("Two stop bits with parity.");
	a_lux_limit: assert property (ce && req.valid && req.func == 8'h03 && req.addr == 16'h0008 |=>
		rsp.data == (($past(lux) > 16'h07d0) ? 16'h07d0 : $past(lux)))
		else $error("Light reading not limited.");
	a_occ_bit: assert property (ce && req.valid && req.func == 8'h03 && req.addr == 16'h0009 |=>
		rsp.data == {15'h0000, $past(occupied)})
		else $error("Presence bit wrong.");
	a_on_ignore: assert property (ce && !nvm_load && req.valid && req.func == 8'h10 && req.addr == 16'h000a &&
		req.data > 16'h012c |=> $stable(settings.on_dly))
		else $error("Oversize turn-on delay stored.");
	a_station_lock: assert property (ce && !nvm_load && req.valid && req.addr == 16'h0004 &&
		q.mode != msr_pkg::MODE_SET |=> $stable(settings.station))
		else $error("Station changed outside setting mode.");

	c_enter_cfg: cover property (q.mode == msr_pkg::MODE_RUN ##1 q.mode == msr_pkg::MODE_CFG);
	c_enter_set: cover property (q.mode == msr_pkg::MODE_CFG ##1 q.mode == msr_pkg::MODE_SET);
	c_exception: cover property (rsp.valid && rsp.exc);
	c_coil_write: cover property (ce && req.valid && req.func == 8'h0f);
endmodule // msr_register_bank

`default_nettype wire

// file: dv/msr_master_model.sv
// Bus master model: issues one request item at a time and returns the answer.
// Assumes the bank answers exactly one cycle after it takes a request.
`timescale 1ns/10ps
`default_nettype none

module msr_master_model (
	// Clock
	input wire logic core_clk,
	// Request and answer
	output var msr_pkg::msr_req_type req,
	input wire msr_pkg::msr_rsp_type rsp
);
	initial begin
		req = '0;
	end

	// The item is held through the taking edge and dropped only once the answer is sampled.
	task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
		output msr_pkg::msr_rsp_type ans);
		@(posedge core_clk);
		#1;
		req = '{1'b1, f, a, d};
		@(posedge core_clk);
		#1;
		ans = rsp;
		req = '0;
	endtask
endmodule // msr_master_model

`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench for the sensor settings bank, driven through the master model.
// Assumes shortened hold, exit and blink counts so that the run stays short.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	localparam int HOLD = 20;
	localparam int EXIT = 200;
	localparam int BLINK = 4;
	// Identification values are arbitrary.
	localparam logic [15:0] PART = 16'h6b02;
	localparam logic [15:0] FWR = 16'h0103;
	localparam logic [15:0] HWR = 16'h0204;
	localparam logic [25:0] OK = 26'h2000000;
	localparam logic [1:0] EXC = 2'b11;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic button_held = 1'b0;
	logic occupied = 1'b0;
	logic [15:0] lux = 16'h0000;
	logic ce = 1'b1;
	logic nvm_load = 1'b0;
	msr_pkg::msr_cfg_type nvm_data = msr_pkg::CFG_DEFAULT;
	msr_pkg::msr_cfg_type settings;
	msr_pkg::msr_req_type req;
	msr_pkg::msr_rsp_type rsp;
	msr_pkg::msr_link_type link_cfg;
	logic nvm_save;
	logic config_active;
	logic indicator_light;
	int num_errors = 0;
	int samples_checked = 0;
	int cycles = 0;

	always #50 core_clk = ~core_clk;

	msr_register_bank #(.HOLD_CYCLES(HOLD), .EXIT_CYCLES(EXIT), .BLINK_CYCLES(BLINK), .PART_ID(PART),
		.FW_REV(FWR), .HW_REV(HWR)) msr_register_bank_inst (.core_clk(core_clk), .rst(rst), .ce(ce),
		.req(req), .rsp(rsp), .button_held(button_held), .occupied(occupied), .lux(lux), .nvm_load(nvm_load),
		.nvm_data(nvm_data), .nvm_save(nvm_save), .settings(settings), .link_cfg(link_cfg),
		.config_active(config_active), .indicator_light(indicator_light));

	msr_master_model msr_master_model_inst (.core_clk(core_clk), .req(req), .rsp(rsp));

	task automatic conclude();
		$display("Counts: %0d mismatches in %0d comparisons", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic xf(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d, input logic [25:0] e);
		msr_pkg::msr_rsp_type r;
		msr_master_model_inst.xfer(f, a, d, r);
		chk({6'h00, r}, {6'h00, e});
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		xf(msr_pkg::FC_WR_REGS, a, d, OK);
	endtask

	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		xf(msr_pkg::FC_RD_HOLD, a, 16'h0000, OK | {10'h000, e});
	endtask

	task automatic t_reset();
		logic [15:0] ofs[11] = '{16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0007,
			16'h000a, 16'h000b, 16'h000c, 16'h000d, 16'h000e};
		logic [15:0] val[11] = '{PART, FWR, HWR, 16'h0001, 16'h0004, 16'h0000,
			16'h0000, 16'h0258, 16'h000f, 16'h0001, 16'h0001};
		for (int i = 0; i < 11; i++) begin
			rd(ofs[i], val[i]);
		end
	endtask

	task automatic t_sensors();
		lux = 16'h0123;
		occupied = 1'b1;
		rd(msr_pkg::OFS_LUX, 16'h0123);
		rd(msr_pkg::OFS_OCC, 16'h0001);
		xf(msr_pkg::FC_RD_COILS, 16'h0090, 16'h0000, OK | 26'h1);
		lux = 16'h0bb8;
		occupied = 1'b0;
		rd(msr_pkg::OFS_LUX, 16'h07d0);
		xf(msr_pkg::FC_RD_COILS, 16'h0090, 16'h0000, OK);
	endtask

	// Each entry: index, written value, value read back, store pulse expected.
	task automatic t_ranges();
		logic [48:0] tbl[12] = '{{16'h000b, 16'h0004, 16'h0258, 1'b0}, {16'h000b, 16'h0005, 16'h0005, 1'b1},
			{16'h000b, 16'h0708, 16'h0708, 1'b1}, {16'h000b, 16'h0709, 16'h0708, 1'b0},
			{16'h000a, 16'h012c, 16'h012c, 1'b1}, {16'h000a, 16'h012d, 16'h012c, 1'b0},
			{16'h000c, 16'h0001, 16'h000f, 1'b0}, {16'h000c, 16'h0002, 16'h0002, 1'b1},
			{16'h000c, 16'h003d, 16'h0002, 1'b0}, {16'h000e, 16'h0003, 16'h0001, 1'b0},
			{16'h000e, 16'h0002, 16'h0002, 1'b1}, {16'h000d, 16'h0000, 16'h0000, 1'b1}};
		for (int i = 0; i < 12; i++) begin
			wr(tbl[i][48:33], tbl[i][32:17]);
			chk({31'h0, nvm_save}, {31'h0, tbl[i][0]});
			rd(tbl[i][48:33], tbl[i][16:1]);
		end
	endtask

	task automatic t_except();
		xf(8'h05, msr_pkg::OFS_STATION, 16'h0000, {EXC, msr_pkg::EX_FUNC, 16'h0000});
		xf(msr_pkg::FC_WR_REGS, msr_pkg::OFS_PART, 16'h1234, {EXC, msr_pkg::EX_ADDR, 16'h0000});
		xf(msr_pkg::FC_RD_HOLD, 16'h0006, 16'h0000, {EXC, msr_pkg::EX_ADDR, 16'h0000});
		rd(msr_pkg::OFS_PART, PART);
	endtask

	task automatic t_coil();
		occupied = 1'b1;
		xf(msr_pkg::FC_WR_COILS, 16'h00d0, 16'h0001, OK);
		rd(msr_pkg::OFS_IND, 16'h0001);
		chk({31'h0, indicator_light}, 32'h1);
		xf(msr_pkg::FC_WR_COILS, 16'h00d0, 16'h0000, OK);
		chk({31'h0, indicator_light}, 32'h0);
		occupied = 1'b0;
	endtask

	task automatic enter_mode();
		button_held = 1'b1;
		tick(HOLD - 1);
		chk({31'h0, config_active}, 32'h0);
		tick(1);
		button_held = 1'b0;
		chk({30'h0, config_active, indicator_light}, 32'h3);
	endtask

	task automatic t_mode();
		logic v;
		wr(msr_pkg::OFS_STATION, 16'h0010);
		rd(msr_pkg::OFS_STATION, 16'h0001);
		enter_mode();
		chk({17'h0, link_cfg}, {17'h0, 8'h01, 4'h4, 2'b00, 1'b0});
		wr(msr_pkg::OFS_CMD, 16'h0001);
		rd(msr_pkg::OFS_OFF, 16'h0258);
		v = indicator_light;
		tick(BLINK);
		chk({31'h0, indicator_light}, {31'h0, ~v});
		wr(msr_pkg::OFS_STATION, 16'h00fb);
		wr(msr_pkg::OFS_STATION, 16'h0010);
		rd(msr_pkg::OFS_STATION, 16'h0010);
		wr(msr_pkg::OFS_LINE, 16'h0305);
		rd(msr_pkg::OFS_LINE, 16'h0004);
		wr(msr_pkg::OFS_LINE, 16'h0405);
		wr(msr_pkg::OFS_CMD, 16'h0002);
		tick(1);
		chk({16'h0, config_active, link_cfg}, {16'h0, 1'b0, 8'h10, 4'h5, 2'b00, 1'b1});
		// Without the closing command the mode must end by itself.
		enter_mode();
		tick(EXIT - 1);
		chk({31'h0, config_active}, 32'h1);
		tick(1);
		chk({31'h0, config_active}, 32'h0);
	endtask

	// Stored image load, freeze while the enable is low, and a reset in mid-run.
	task automatic t_store();
		msr_pkg::msr_cfg_type img;
		img = '{16'h0022, 16'h0006, 16'h000a, 16'h0100, 16'h0010, 16'h0000, 16'h0002};
		nvm_data = img;
		ce = 1'b0;
		nvm_load = 1'b1;
		tick(3);
		chk({settings.station, settings.line}, {16'h0010, 16'h0405});
		ce = 1'b1;
		tick(1);
		nvm_load = 1'b0;
		chk({settings.station, settings.off_dly}, {16'h0022, 16'h0100});
		chk({17'h0, link_cfg}, {17'h0, 8'h22, 4'h6, 2'b00, 1'b0});
		rd(msr_pkg::OFS_SENS, 16'h0002);
		rst = 1'b1;
		tick(2);
		rst = 1'b0;
		chk({settings.station, settings.off_dly}, {16'h0001, 16'h0258});
		rd(msr_pkg::OFS_LINE, 16'h0004);
	endtask

	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			conclude();
		end
	end

	initial begin
		tick(12);
		rst = 1'b0;
		t_reset();
		t_sensors();
		t_ranges();
		t_except();
		t_coil();
		t_mode();
		t_store();
		conclude();
	end
endmodule // tb_top

`default_nettype wire
